// >>> src/adcc_ctrl.sv
// Converter control word, scan sequencer, DAC latches and APB slave
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module adcc_ctrl
    import adcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output adcc_conv_req_t conv_req,
    input wire adcc_conv_rsp_t conv_rsp,
    input wire logic [ADCC_ADC_CH-1:0] alarm_event,
    output adcc_dac_bank_t dac_level,
    output logic ref_buffer_on,
    output logic ref_internal_sel,
    output logic alarm_n,
    output logic data_ready_pin_n,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Lowest enabled channel at or above a start index
    function automatic logic [4:0] adcc_find(input logic [15:0] en, input logic [4:0] from);
        logic [4:0] r;
        r = 5'h00;
        for (int i = ADCC_ADC_CH - 1; i >= 0; i--) begin
            if (i >= int'(from) && en[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : adcc_find

    adcc_state_t s;
    adcc_state_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pready = 1'b1; // Read data is staged in the setup cycle, so no waits
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    // One driver for the whole request struct
    assign conv_req = '{start: s.adc_start, channel: s.chan};
    assign dac_level = s.dac_latch;
    assign ref_buffer_on = s.ref_int;
    assign ref_internal_sel = s.ref_int;
    assign alarm_n = ~(s.alarm_en & (|s.alarm_stat));
    // Level in one-shot mode, timed pulse in repeating mode
    assign data_ready_pin_n = s.repeat_sel ? (s.pulse_cnt == 8'h00) : ~s.done_flag;
    assign irq = |(s.irq_stat & s.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic setup;
        logic wr;
        logic rd;
        logic [15:0] wm;
        logic [15:0] wd;
        logic [15:0] ctrl_rd;
        logic [4:0] f;
        logic pass_end;
        logic [ADCC_IRQ_W-1:0] ev;
        setup = psel & ~penable;
        wr = psel & penable & pwrite & ~s.pslverr;
        rd = psel & penable & ~pwrite & ~s.pslverr;
        wm = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        wd = pwdata[15:0] & wm;
        ctrl_rd = 16'h0000;
        f = 5'h00;
        pass_end = 1'b0;
        ev = '0;
        next_s = s;
        next_s.adc_start = 1'b0;

        // Read image of the control word, reserved bits zero
        ctrl_rd[ADCC_BIT_REPEAT] = s.repeat_sel;
        ctrl_rd[ADCC_BIT_TRIG] = s.conv_trig;
        ctrl_rd[ADCC_BIT_LOAD] = s.load_trig;
        ctrl_rd[ADCC_BIT_REF] = s.ref_int;
        ctrl_rd[ADCC_BIT_ALEN] = s.alarm_en;
        ctrl_rd[ADCC_BIT_DONE] = s.done_flag & ~s.repeat_sel;
        ctrl_rd[ADCC_BIT_FAULT] = s.fault_flag;

        // Setup phase: decode and stage read data
        if (setup) begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
            if (paddr[1:0] != 2'b00) begin
                next_s.pslverr = 1'b1;
            end else if (paddr == ADCC_OFF_CTRL) begin
                next_s.prdata = {16'h0000, ctrl_rd};
            end else if (paddr == ADCC_OFF_CHEN) begin
                next_s.prdata = {16'h0000, s.chan_en};
            end else if (paddr == ADCC_OFF_SYNC) begin
                next_s.prdata = {20'h00000, s.sync_sel};
            end else if (paddr == ADCC_OFF_ALST) begin
                next_s.prdata = {16'h0000, s.alarm_stat};
            end else if (paddr == ADCC_OFF_IRQST) begin
                next_s.prdata = {29'h0000_0000, s.irq_stat};
            end else if (paddr == ADCC_OFF_IRQMSK) begin
                next_s.prdata = {29'h0000_0000, s.irq_mask};
            end else if (paddr[11:6] == ADCC_OFF_ADC[11:6]) begin
                next_s.prdata = {20'h00000, s.adc_data[paddr[5:2]]};
            end else if (paddr[11:6] == ADCC_OFF_DAC[11:6] && paddr[5:2] < 4'(ADCC_DAC_CH)) begin
                next_s.prdata = {20'h00000, s.dac_data[paddr[5:2]]};
            end else begin
                next_s.pslverr = 1'b1;
            end
        end

        // Access phase reads with side effects
        if (rd && paddr[11:6] == ADCC_OFF_ADC[11:6]) begin
            next_s.done_flag = 1'b0;
        end
        if (rd && paddr == ADCC_OFF_ALST) begin
            // Done flag untouched here
            next_s.alarm_stat = '0;
            next_s.fault_flag = 1'b0;
        end

        // Access phase writes
        if (wr && paddr == ADCC_OFF_CTRL) begin
            // Only named fields take writes
            if (wm[ADCC_BIT_REPEAT]) begin
                next_s.repeat_sel = wd[ADCC_BIT_REPEAT];
            end
            if (wm[ADCC_BIT_REF]) begin
                next_s.ref_int = wd[ADCC_BIT_REF];
            end
            if (wm[ADCC_BIT_ALEN]) begin
                next_s.alarm_en = wd[ADCC_BIT_ALEN];
            end
            // Triggers only set; a zero leaves them alone
            if (wd[ADCC_BIT_TRIG]) begin
                next_s.conv_trig = 1'b1;
            end
            if (wd[ADCC_BIT_LOAD]) begin
                next_s.load_trig = 1'b1;
            end
            if (wm[ADCC_BIT_DONE] && !wd[ADCC_BIT_DONE]) begin
                next_s.done_flag = 1'b0;
            end
        end
        if (wr && paddr == ADCC_OFF_CHEN) begin
            next_s.chan_en = (s.chan_en & ~wm) | wd;
        end
        if (wr && paddr == ADCC_OFF_SYNC) begin
            next_s.sync_sel = (s.sync_sel & ~wm[11:0]) | wd[11:0];
        end
        if (wr && paddr == ADCC_OFF_IRQST) begin
            next_s.irq_stat = s.irq_stat & ~wd[ADCC_IRQ_W-1:0];
        end
        if (wr && paddr == ADCC_OFF_IRQMSK) begin
            next_s.irq_mask = (s.irq_mask & ~wm[ADCC_IRQ_W-1:0]) | wd[ADCC_IRQ_W-1:0];
        end

        // Synchronous DAC load; a write in the same cycle stays dirty
        if (s.load_trig) begin
            for (int c = 0; c < ADCC_DAC_CH; c++) begin
                if (s.sync_sel[c] && s.dac_dirty[c]) begin
                    next_s.dac_latch[c] = s.dac_data[c];
                    next_s.dac_dirty[c] = 1'b0;
                end
            end
            next_s.load_trig = 1'b0;
            ev[ADCC_IRQ_LOAD] = 1'b1;
        end

        // DAC data writes; asynchronous channels follow at once
        if (wr && paddr[11:6] == ADCC_OFF_DAC[11:6] && paddr[5:2] < 4'(ADCC_DAC_CH)) begin
            next_s.dac_data[paddr[5:2]] = (s.dac_data[paddr[5:2]] & ~wm[11:0]) | wd[11:0];
            next_s.dac_dirty[paddr[5:2]] = 1'b1;
            if (!s.sync_sel[paddr[5:2]]) begin
                next_s.dac_latch[paddr[5:2]] = (s.dac_data[paddr[5:2]] & ~wm[11:0]) | wd[11:0];
            end
        end

        // Scan sequencer
        unique case (s.scan)
            ADCC_IDLE: begin
                if (s.conv_trig) begin
                    next_s.conv_trig = 1'b0;
                    next_s.done_flag = 1'b0;
                    f = adcc_find(s.chan_en, 5'h00);
                    if (f[4]) begin
                        next_s.chan = f[3:0];
                        next_s.adc_start = 1'b1;
                        next_s.scan = ADCC_CONV;
                    end else begin
                        pass_end = 1'b1; // Empty scan list ends at once
                    end
                end
            end
            ADCC_CONV: begin
                if (conv_rsp.done) begin
                    next_s.adc_data[s.chan] = conv_rsp.data;
                    f = adcc_find(s.chan_en, {1'b0, s.chan} + 5'h01);
                    if (f[4]) begin
                        next_s.chan = f[3:0];
                        next_s.adc_start = 1'b1;
                    end else begin
                        pass_end = 1'b1;
                    end
                end
            end
        endcase

        // End of a pass: loop or go idle
        if (pass_end) begin
            ev[ADCC_IRQ_SCAN] = 1'b1;
            f = adcc_find(s.chan_en, 5'h00);
            if (s.repeat_sel && f[4]) begin
                next_s.chan = f[3:0];
                next_s.adc_start = 1'b1;
                next_s.scan = ADCC_CONV;
                next_s.pulse_cnt = ADCC_DRDY_PULSE_CYC;
            end else begin
                next_s.scan = ADCC_IDLE;
                if (s.repeat_sel) begin
                    next_s.pulse_cnt = ADCC_DRDY_PULSE_CYC;
                end else begin
                    next_s.done_flag = 1'b1;
                end
            end
        end else if (s.pulse_cnt != 8'h00) begin
            next_s.pulse_cnt = s.pulse_cnt - 8'h01;
        end

        // Flag stays zero while repeating
        if (next_s.repeat_sel) begin
            next_s.done_flag = 1'b0;
        end

        // Alarm events win over a clearing read
        if (|alarm_event) begin
            next_s.alarm_stat = next_s.alarm_stat | alarm_event;
            next_s.fault_flag = 1'b1;
            ev[ADCC_IRQ_ALARM] = 1'b1;
        end
        next_s.irq_stat = next_s.irq_stat | ev;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.repeat_sel <= ADCC_RST_REPEAT;
            s.chan_en <= ADCC_RST_CHEN;
            s.sync_sel <= ADCC_RST_SYNC;
            s.irq_mask <= ADCC_RST_IRQMSK;
            s.scan <= ADCC_IDLE;
        end else begin
            s <= next_s;
        end
    end

endmodule : adcc_ctrl

`default_nettype wire

// >>> pkg/adcc_pkg.sv
// Constants, state types and carriers for the converter control block
package adcc_pkg;
    // Register byte offsets
    localparam logic [11:0] ADCC_OFF_CTRL = 12'h000;
    localparam logic [11:0] ADCC_OFF_CHEN = 12'h004;
    localparam logic [11:0] ADCC_OFF_SYNC = 12'h008;
    localparam logic [11:0] ADCC_OFF_ALST = 12'h00C;
    localparam logic [11:0] ADCC_OFF_IRQST = 12'h010;
    localparam logic [11:0] ADCC_OFF_IRQMSK = 12'h014;
    localparam logic [11:0] ADCC_OFF_ADC = 12'h040;
    localparam logic [11:0] ADCC_OFF_DAC = 12'h080;
    // Channel counts and widths
    localparam int ADCC_ADC_CH = 16;
    localparam int ADCC_DAC_CH = 12;
    localparam int ADCC_DW = 12;
    localparam int ADCC_IRQ_W = 3;
    // Control word field positions
    localparam int ADCC_BIT_REPEAT = 13;
    localparam int ADCC_BIT_TRIG = 12;
    localparam int ADCC_BIT_LOAD = 11;
    localparam int ADCC_BIT_REF = 10;
    localparam int ADCC_BIT_ALEN = 9;
    localparam int ADCC_BIT_DONE = 7;
    localparam int ADCC_BIT_FAULT = 6;
    // Interrupt status bit positions
    localparam int ADCC_IRQ_SCAN = 0;
    localparam int ADCC_IRQ_LOAD = 1;
    localparam int ADCC_IRQ_ALARM = 2;
    // Reset values
    localparam logic ADCC_RST_REPEAT = 1'b1;
    localparam logic [15:0] ADCC_RST_CHEN = 16'h0000;
    localparam logic [11:0] ADCC_RST_SYNC = 12'h000;
    localparam logic [2:0] ADCC_RST_IRQMSK = 3'h0;
    // Data-ready pulse in repeating mode
    localparam int ADCC_CLK_NS = 10;
    localparam int ADCC_DRDY_PULSE_NS = 1000;
    localparam logic [7:0] ADCC_DRDY_PULSE_CYC = 8'((ADCC_DRDY_PULSE_NS + ADCC_CLK_NS - 1) / ADCC_CLK_NS);

    typedef enum logic {
        ADCC_IDLE = 1'b0,
        ADCC_CONV = 1'b1
    } adcc_scan_t;

    typedef logic [ADCC_DAC_CH-1:0][ADCC_DW-1:0] adcc_dac_bank_t;

    // Converter request and answer
    typedef struct packed {
        logic start;
        logic [3:0] channel;
    } adcc_conv_req_t;

    typedef struct packed {
        logic done;
        logic [ADCC_DW-1:0] data;
    } adcc_conv_rsp_t;

    typedef struct packed {
        logic repeat_sel;
        logic conv_trig;
        logic load_trig;
        logic ref_int;
        logic alarm_en;
        logic done_flag;
        logic fault_flag;
        logic [ADCC_ADC_CH-1:0] chan_en;
        logic [ADCC_DAC_CH-1:0] sync_sel;
        logic [ADCC_ADC_CH-1:0] alarm_stat;
        logic [ADCC_IRQ_W-1:0] irq_stat;
        logic [ADCC_IRQ_W-1:0] irq_mask;
        logic [ADCC_ADC_CH-1:0][ADCC_DW-1:0] adc_data;
        logic [ADCC_DAC_CH-1:0][ADCC_DW-1:0] dac_data;
        logic [ADCC_DAC_CH-1:0] dac_dirty;
        adcc_dac_bank_t dac_latch;
        adcc_scan_t scan;
        logic [3:0] chan;
        logic adc_start;
        logic [7:0] pulse_cnt;
        logic [31:0] prdata;
        logic pslverr;
    } adcc_state_t;
endpackage : adcc_pkg

// >>> sim/adcc_checker.sv
// Port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcc_checker
    import adcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire adcc_conv_req_t conv_req,
    input wire adcc_conv_rsp_t conv_rsp,
    input wire logic [ADCC_ADC_CH-1:0] alarm_event,
    input wire adcc_dac_bank_t dac_level,
    input wire logic ref_buffer_on,
    input wire logic ref_internal_sel,
    input wire logic alarm_n,
    input wire logic data_ready_pin_n,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Read access of the control word
    wire logic rd_ctrl = psel && penable && !pwrite && paddr == ADCC_OFF_CTRL;
    wire logic wr_acc = psel && penable && pwrite;
    ////////////////////////////////////////////////////////////////////////////
    chk_ref_pair: assert property (ref_buffer_on == ref_internal_sel)
        else $error("reference buffer and source disagree");
    chk_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("start longer than one cycle");
    chk_dac_cause: assert property ($changed(dac_level) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("latch changed without a write");
    chk_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_ctrl_rsvd: assert property (rd_ctrl |-> prdata[8] == 1'b0 && prdata[5:0] == 6'h00)
        else $error("reserved control bits not zero");
    chk_done_auto: assert property (rd_ctrl && prdata[13] |-> !prdata[7])
        else $error("done flag set in repeat mode");
    chk_alarm_fault: assert property (rd_ctrl && $past(!alarm_n) |-> prdata[9] && prdata[6])
        else $error("alarm pin low without fault flag");
    chk_drdy_hold: assert property ($fell(data_ready_pin_n) |-> !data_ready_pin_n [*8])
        else $error("data ready low too briefly");
    // Main scenarios reached
    cover property ($fell(data_ready_pin_n));
    cover property ($changed(dac_level));
    cover property ($fell(alarm_n));
    cover property ($rose(irq));
endmodule : adcc_checker

bind adcc_ctrl adcc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_req(conv_req), .conv_rsp(conv_rsp), .alarm_event(alarm_event),
    .dac_level(dac_level), .ref_buffer_on(ref_buffer_on), .ref_internal_sel(ref_internal_sel),
    .alarm_n(alarm_n), .data_ready_pin_n(data_ready_pin_n), .irq(irq));
`default_nettype wire

// >>> sim/adcc_conv_model.sv
// Behavioural converter answering start requests promptly or slowly
`timescale 1ns/1ns
`default_nettype none
module adcc_conv_model
    import adcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire adcc_conv_req_t conv_req,
    input wire logic slow,
    output adcc_conv_rsp_t conv_rsp
);
    logic busy;
    logic [3:0] ch;
    logic [7:0] cnt;
    // Data toggles while no answer is due, so a stale result never matches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            ch <= 4'h0;
            cnt <= 8'h00;
            conv_rsp <= '0;
        end else begin
            conv_rsp.done <= 1'b0;
            conv_rsp.data <= ~conv_rsp.data;
            if (conv_req.start) begin
                busy <= 1'b1;
                ch <= conv_req.channel;
                cnt <= slow ? 8'h1E : 8'h01;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                conv_rsp <= {1'b1, {ch, ch, ch} ^ 12'h5A3};
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : adcc_conv_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import adcc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, ref_buffer_on, ref_internal_sel, alarm_n, data_ready_pin_n, irq;
    logic [ADCC_ADC_CH-1:0] alarm_event = 16'h0000, chen, ev;
    adcc_conv_req_t conv_req;
    adcc_conv_rsp_t conv_rsp;
    adcc_dac_bank_t dac_level, dexp, dv;
    logic [3:0] seq[$];
    logic [11:0] sm;
    int seed = 43, n_mismatch = 0, n_checks = 0, cyc = 0, k, w, lc;
    adcc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_req(conv_req), .conv_rsp(conv_rsp), .alarm_event(alarm_event), .dac_level(dac_level),
        .ref_buffer_on(ref_buffer_on), .ref_internal_sel(ref_internal_sel), .alarm_n(alarm_n),
        .data_ready_pin_n(data_ready_pin_n), .irq(irq));
    adcc_conv_model u_conv (.pclk(pclk), .presetn(presetn), .conv_req(conv_req), .slow(slow),
        .conv_rsp(conv_rsp));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Hang guard and record of started channels
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            summarize();
        end
        if (conv_req.start === 1'b1) seq.push_back(conv_req.channel);
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Whole APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge: register effects settle before the caller looks
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd & m);
    endtask : rdc
    // Bounded wait for a data-ready level
    task automatic wt(input logic lvl);
        for (int i = 0; i < 3000 && data_ready_pin_n !== lvl; i++) @(posedge pclk);
    endtask : wt
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("ctrl rst", ADCC_OFF_CTRL, 32'hFFFFFFFF, 32'h00002000);
        chk("ref off", 32'h00000000, {31'h0, ref_internal_sel});
        apb(1'b1, ADCC_OFF_CTRL, 32'h000007BF);
        rdc("ctrl rsvd", ADCC_OFF_CTRL, 32'hFFFFFFFF, 32'h00000600);
        chk("ref on", 32'h00000001, {31'h0, ref_buffer_on});
        chk("ref sel", 32'h00000001, {31'h0, ref_internal_sel});
        // One-shot pass over random channels
        chen = 16'($random(seed)) & 16'h00FF | 16'h0001;
        apb(1'b1, ADCC_OFF_CHEN, {16'h0000, chen});
        seq.delete();
        apb(1'b1, ADCC_OFF_CTRL, 32'h00001600);
        wt(1'b0);
        k = 0;
        for (int c = 0; c < 16; c++) begin
            if (chen[c]) begin
                chk("chan", 32'(c), 32'(seq[k]));
                k++;
                lc = c;
            end
        end
        repeat (20) @(posedge pclk);
        chk("idle", 32'(k), 32'(seq.size()));
        apb(1'b0, ADCC_OFF_ALST, 32'h00000000);
        rdc("done", ADCC_OFF_CTRL, 32'h00001080, 32'h00000080);
        chk("drdy low", 32'h0, {31'h0, data_ready_pin_n});
        chk("irq off", 32'h0, {31'h0, irq});
        apb(1'b1, ADCC_OFF_IRQMSK, 32'h00000001);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, ADCC_OFF_IRQST, 32'h00000007);
        chk("irq clr", 32'h0, {31'h0, irq});
        rdc("adc", ADCC_OFF_ADC + 12'(4 * lc), 32'h00000FFF, {20'h0, {lc[3:0], lc[3:0], lc[3:0]} ^ 12'h5A3});
        chk("drdy rd", 32'h1, {31'h0, data_ready_pin_n});
        // Writing zero to the trigger mid-pass does not abort it
        apb(1'b1, ADCC_OFF_CTRL, 32'h00001600);
        apb(1'b1, ADCC_OFF_CTRL, 32'h00000600);
        wt(1'b0);
        chk("no abort", 32'h0, {31'h0, data_ready_pin_n});
        repeat (10) @(posedge pclk);
        apb(1'b1, ADCC_OFF_CTRL, 32'h00000600);
        chk("drdy wr0", 32'h1, {31'h0, data_ready_pin_n});
        // Repeat mode with a slow converter
        slow <= 1'b1;
        apb(1'b1, ADCC_OFF_CHEN, 32'h000000F0);
        seq.delete();
        apb(1'b1, ADCC_OFF_CTRL, 32'h00003600);
        wt(1'b0);
        for (w = 0; w < 300 && data_ready_pin_n === 1'b0; w++) @(posedge pclk);
        chk("pulse", 32'(ADCC_DRDY_PULSE_CYC), 32'(w));
        chk("restart", 32'h4, 32'(seq[4]));
        rdc("auto", ADCC_OFF_CTRL, 32'h00003E80, 32'h00002600);
        apb(1'b1, ADCC_OFF_CTRL, 32'h00000600);
        wt(1'b0);
        k = seq.size();
        repeat (150) @(posedge pclk);
        chk("stop", 32'(k), 32'(seq.size()));
        // Sync and direct DAC channels
        slow <= 1'b0;
        sm = 12'($random(seed));
        apb(1'b1, ADCC_OFF_SYNC, {20'h0, sm});
        dexp = '0;
        for (int c = 0; c < 12; c++) begin
            dv[c] = 12'($random(seed));
            apb(1'b1, ADCC_OFF_DAC + 12'(4 * c), {20'hFFFFF, dv[c]});
            if (!sm[c]) dexp[c] = dv[c];
            chk("dac imm", {20'h0, dexp[c]}, {20'h0, dac_level[c]});
        end
        apb(1'b1, ADCC_OFF_CTRL, 32'h00000E00);
        repeat (2) @(posedge pclk);
        for (int c = 0; c < 12; c++) chk("dac load", {20'h0, dv[c]}, {20'h0, dac_level[c]});
        rdc("load clr", ADCC_OFF_CTRL, 32'h00000800, 32'h00000000);
        // Alarm gating and sticky fault flag
        apb(1'b1, ADCC_OFF_CTRL, 32'h00000400);
        ev = 16'($random(seed)) | 16'h0001;
        alarm_event <= ev;
        @(posedge pclk);
        alarm_event <= 16'h0000;
        @(posedge pclk);
        chk("alarm off", 32'h1, {31'h0, alarm_n});
        apb(1'b1, ADCC_OFF_CTRL, 32'h00000600);
        chk("alarm on", 32'h0, {31'h0, alarm_n});
        rdc("fault", ADCC_OFF_CTRL, 32'h00000040, 32'h00000040);
        rdc("alst", ADCC_OFF_ALST, 32'h0000FFFF, {16'h0, ev});
        chk("alarm clr", 32'h1, {31'h0, alarm_n});
        rdc("fault clr", ADCC_OFF_CTRL, 32'h00000040, 32'h00000000);
        // Unmapped address is refused
        apb(1'b0, 12'h0FC, 32'h00000000);
        chk("slverr", 32'h1, {31'h0, pslverr});
        summarize();
    end
endmodule : tb_top
`default_nettype wire
